// File: rtl/scm_clock_mode_ctl.sv
// scm_clock_mode_ctl: system clock selection, divider and power mode control.
// assumes the cpu gives a one-cycle halt pulse and a wake pulse on core_clk; oscillator
// outputs and their ready levels arrive asynchronously and are resynchronised here.
// Contract
// - gate conversion clock by enable in slow modes
// - fast mode divides fast oscillator by 1..64
// - slow mode runs cpu from slow oscillator
// - halt with both keep bits low sleeps
// - sleep keeps slow oscillator while watchdog on
// - halt, fast low slow high: idle_slow_only
// - halt, both keep bits high: idle_both_osc
// - halt, fast high slow low: idle_fast_only
// - selector codes 0..6 divide, 7 slow
// - unimplemented control bits read zero
// - fast keep bit holds fast oscillator in halt
// - slow keep bit holds peripheral slow clock in halt
// - enabling fast oscillator clears then sets stable flag
// - power-down entry sets flag, clears timeout, watchdog
// - slow mode fast clock follows enable bit
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module scm_clock_mode_ctl
    import scm_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_we,
    input  wire logic                 reg_re,
    output logic      [7:0]           reg_rdata,
    input  wire logic                 power_down_instruction,
    input  wire logic                 wake_req,
    input  wire logic                 watchdog_en,
    input  wire logic                 auto_conversion_en,
    input  wire logic                 fast_rc_osc,
    input  wire logic                 slow_rc_osc,
    input  wire logic                 fast_osc_ready,
    input  wire logic                 slow_osc_ready,
    output scm_osc_ctl_t              osc_ctl,
    output scm_clk_en_t               clk_en,
    output scm_pd_evt_t               pd_evt,
    output scm_state_t                power_state,
    output logic                      cpu_on,
    output logic      [2:0]           active_sel
);

    logic [SCM_IN_W-1:0]  sync1_q;
    logic [SCM_IN_W-1:0]  sync2_q;
    logic [SCM_IN_W-1:0]  sync3_q;
    logic [SCM_IN_W-1:0]  lvl_q;
    logic [SCM_IN_W-1:0]  rise;

    logic [2:0]           sel_q;
    logic                 fkeep_q;
    logic                 skeep_q;
    logic                 fen_q;
    logic                 fstab_q;
    logic [7:0]           rdata_q;
    scm_state_t           state_q;
    logic [2:0]           act_q;
    logic [SCM_DIV_W-1:0] cnt_q;
    logic [SCM_DIV_W-1:0] div_mask;
    logic                 fast_tick;
    logic                 src_tick;
    logic                 run;
    logic                 act_slow;
    logic                 tgt_slow;
    logic                 tgt_ok;
    logic                 fast_run;
    logic                 slow_rc_osc_run;
    logic                 fsub_on;
    logic                 acf_on;
    logic                 fen_wr_rise;
    logic                 halt_go;
    logic                 old_lost;
    logic                 sw_go;

    // only the second stage onwards is read; the first may be metastable
    // a level is taken once the second and third stages agree
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= {slow_osc_ready, fast_osc_ready, slow_rc_osc, fast_rc_osc};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lvl_q <= '0;
        end else begin
            for (int i = 0; i < SCM_IN_W; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    lvl_q[i] <= sync2_q[i];
                end
            end
        end
    end

    // an edge is seen only if its source runs no faster than core_clk/4
    always_comb begin
        for (int i = 0; i < SCM_IN_W; i++) begin
            rise[i] = (sync2_q[i] == sync3_q[i]) && sync2_q[i] && !lvl_q[i];
        end
    end

    // selector code 7 picks the slow source, 0..6 the divided fast one
    assign run      = (state_q == SCM_ST_RUN);
    assign act_slow = (act_q == SCM_SEL_SLOW);
    assign tgt_slow = (sel_q == SCM_SEL_SLOW);
    // a halt is honoured only while running
    assign halt_go  = run && power_down_instruction;

    // control register writes
    // bits 4..2 are not stored, so they always read back zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel_q   <= SCM_SCC_RST[SCM_SEL_MSB:SCM_SEL_LSB];
            fkeep_q <= SCM_SCC_RST[SCM_FKEEP_BIT];
            skeep_q <= SCM_SCC_RST[SCM_SKEEP_BIT];
        end else if (reg_we && reg_addr == SCM_SCC_ADDR) begin
            sel_q   <= reg_wdata[SCM_SEL_MSB:SCM_SEL_LSB];
            fkeep_q <= reg_wdata[SCM_FKEEP_BIT];
            skeep_q <= reg_wdata[SCM_SKEEP_BIT];
        end
    end

    assign fen_wr_rise = reg_we && reg_addr == SCM_FOC_ADDR && reg_wdata[SCM_FEN_BIT] && !fen_q;

    // enable resets high, so the fast oscillator runs from power-up
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fen_q <= SCM_FEN_RST;
        end else if (reg_we && reg_addr == SCM_FOC_ADDR) begin
            fen_q <= reg_wdata[SCM_FEN_BIT];
        end
    end

    // stable flag drops whenever the oscillator is off or freshly enabled
    // clear wins over set: an enable write must restart the wait for stability
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fstab_q <= SCM_FSTAB_RST;
        end else if (!fast_run || fen_wr_rise) begin
            fstab_q <= 1'b0;
        end else if (lvl_q[SCM_IN_FRDY]) begin
            fstab_q <= 1'b1;
        end
    end

    // read data stands in the cycle after the strobe only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (reg_re) begin
            case (reg_addr)
                SCM_SCC_ADDR: rdata_q <= {sel_q, 3'h0, fkeep_q, skeep_q};
                SCM_FOC_ADDR: rdata_q <= {6'h00, fstab_q, fen_q};
                default:      rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;

    // power mode sequencing
    // a halt outside run and a wake inside run are both ignored
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= SCM_ST_RUN;
        end else begin
            case (state_q)
                SCM_ST_RUN: begin
                    if (power_down_instruction) begin
                        case ({fkeep_q, skeep_q})
                            2'b00:   state_q <= SCM_ST_SLEEP;
                            2'b01:   state_q <= SCM_ST_IDLE_SLOW_ONLY;
                            2'b11:   state_q <= SCM_ST_IDLE_BOTH_OSC;
                            default: state_q <= SCM_ST_IDLE_FAST_ONLY;
                        endcase
                    end
                end
                SCM_ST_SLEEP,
                SCM_ST_IDLE_SLOW_ONLY,
                SCM_ST_IDLE_BOTH_OSC,
                SCM_ST_IDLE_FAST_ONLY: begin
                    if (wake_req) begin
                        state_q <= SCM_ST_RUN;
                    end
                end
                // an illegal state code falls back to run
                default: state_q <= SCM_ST_RUN;
            endcase
        end
    end

    // entry events last exactly one cycle
    // a second halt cannot follow at once, since halt_go needs the run state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pd_evt <= '0;
        end else begin
            pd_evt.power_down_flag_set       <= halt_go;
            pd_evt.watchdog_timeout_flag_clr <= halt_go;
            pd_evt.watchdog_counter_clr      <= halt_go;
        end
    end

    // oscillator run requests per mode
    // in run the fast source stops only when slow is chosen and in effect
    always_comb begin
        case (state_q)
            SCM_ST_RUN:   fast_run = !act_slow || !tgt_slow || fen_q;
            SCM_ST_IDLE_BOTH_OSC,
            SCM_ST_IDLE_FAST_ONLY: fast_run = fkeep_q;
            default:      fast_run = 1'b0;
        endcase
    end

    always_comb begin
        case (state_q)
            // watchdog and conversion unit both live on the slow oscillator
            SCM_ST_SLEEP: slow_rc_osc_run = watchdog_en || auto_conversion_en;
            default:      slow_rc_osc_run = 1'b1;
        endcase
    end

    always_comb begin
        case (state_q)
            SCM_ST_RUN,
            SCM_ST_IDLE_SLOW_ONLY,
            SCM_ST_IDLE_BOTH_OSC: fsub_on = run || skeep_q;
            // idle_fast_only and sleep stop the peripheral slow clock
            default:      fsub_on = 1'b0;
        endcase
    end

    // conversion clock is free-running only where the fast clock runs
    always_comb begin
        case (state_q)
            SCM_ST_RUN:   acf_on = !act_slow || auto_conversion_en;
            SCM_ST_IDLE_BOTH_OSC,
            SCM_ST_IDLE_FAST_ONLY: acf_on = 1'b1;
            default:      acf_on = auto_conversion_en;
        endcase
    end

    // run requests are levels; the oscillator macros own their start-up delay
    assign osc_ctl.fast_osc_run = fast_run;
    assign osc_ctl.slow_osc_run = slow_rc_osc_run;

    // divide ratio 2**code; mask of the low counter bits
    assign div_mask  = SCM_DIV_W'((7'h01 << act_q) - 7'h01);
    assign fast_tick = rise[SCM_IN_FOSC] && fstab_q && ((cnt_q & div_mask) == div_mask);
    // slow code gives one cpu tick per slow edge, with no divider
    assign src_tick  = act_slow ? rise[SCM_IN_SOSC] : fast_tick;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (sw_go) begin
            // restart with the new source so its first period is whole
            cnt_q <= '0;
        end else if (rise[SCM_IN_FOSC] && fstab_q && !act_slow) begin
            cnt_q <= fast_tick ? '0 : cnt_q + SCM_DIV_W'(1);
        end
    end

    // the target source must be stable; a change waits for a period boundary unless the old source has lost its stable level
    assign tgt_ok = tgt_slow ? lvl_q[SCM_IN_SRDY] : fstab_q;

    // an old source that has lost its stable level gives no boundary to wait for
    assign old_lost = act_slow ? !lvl_q[SCM_IN_SRDY] : !fstab_q;
    assign sw_go    = (act_q != sel_q) && tgt_ok && (src_tick || old_lost);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            act_q <= SCM_SCC_RST[SCM_SEL_MSB:SCM_SEL_LSB];
        end else if (sw_go) begin
            act_q <= sel_q;
        end
    end

    // enables are one-cycle strobes; a halted cpu sees none
    // consumers gate their own flops with these; no derived clock leaves
    always_comb begin
        clk_en.cpu_clk_en  = run && src_tick;
        clk_en.fast_clk_en = fast_run && fstab_q && rise[SCM_IN_FOSC];
        clk_en.slow_clk_en = fsub_on && rise[SCM_IN_SOSC];
        clk_en.slow_rc_osc_clk_en = slow_rc_osc_run && rise[SCM_IN_SOSC];
        clk_en.acf_clk_en  = acf_on && rise[SCM_IN_SOSC];
    end

    assign power_state = state_q;
    assign cpu_on      = run;
    assign active_sel  = act_q;

endmodule

// File: shared/scm_pkg.sv
// scm_pkg: constants and carrier types for the system clock and power mode controller.
// assumes a single core clock; oscillator pins are asynchronous and synchronised in the block.
package scm_pkg;

    localparam logic [7:0] SCM_SCC_ADDR   = 8'h00;
    localparam logic [7:0] SCM_FOC_ADDR   = 8'h01;

    localparam int         SCM_SEL_MSB    = 7;
    localparam int         SCM_SEL_LSB    = 5;
    localparam int         SCM_FKEEP_BIT  = 1;
    localparam int         SCM_SKEEP_BIT  = 0;
    localparam int         SCM_FSTAB_BIT  = 1;
    localparam int         SCM_FEN_BIT    = 0;

    localparam logic [7:0] SCM_SCC_RST    = 8'h00;
    localparam logic       SCM_FEN_RST    = 1'b1;
    localparam logic       SCM_FSTAB_RST  = 1'b0;

    localparam logic [2:0] SCM_SEL_SLOW   = 3'h7;
    localparam int         SCM_DIV_W      = 6;

    // async input vector positions
    localparam int         SCM_IN_FOSC    = 0;
    localparam int         SCM_IN_SOSC    = 1;
    localparam int         SCM_IN_FRDY    = 2;
    localparam int         SCM_IN_SRDY    = 3;
    localparam int         SCM_IN_W       = 4;

    typedef enum logic [2:0] {
        SCM_ST_RUN   = 3'h0,
        SCM_ST_SLEEP = 3'h1,
        SCM_ST_IDLE_SLOW_ONLY = 3'h3,
        SCM_ST_IDLE_BOTH_OSC = 3'h2,
        SCM_ST_IDLE_FAST_ONLY = 3'h6
    } scm_state_t;

    // oscillator run requests towards the analog macros
    typedef struct packed {
        logic fast_osc_run;
        logic slow_osc_run;
    } scm_osc_ctl_t;

    // one-cycle clock enables for cpu and peripherals
    typedef struct packed {
        logic cpu_clk_en;
        logic fast_clk_en;
        logic slow_clk_en;
        logic slow_rc_osc_clk_en;
        logic acf_clk_en;
    } scm_clk_en_t;

    // pulses raised on entry to a power-down mode
    typedef struct packed {
        logic power_down_flag_set;
        logic watchdog_timeout_flag_clr;
        logic watchdog_counter_clr;
    } scm_pd_evt_t;

endpackage

// File: test/scm_clock_mode_ctl_tb.sv
// scm_clock_mode_ctl_tb: self-checking bench for the clock and power mode controller.
// assumes behavioural oscillators; fast period 16 core cycles, slow period 80.
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL t=%0t got %h exp %h", $time, (g), (e)); end end
module scm_clock_mode_ctl_tb
    import scm_pkg::*;
;
    logic         core_clk = 1'b0;
    logic         rst = 1'b1;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata;
    logic         reg_we, reg_re, power_down_instruction, wake_req;
    logic         watchdog_en, auto_conversion_en, cpu_on;
    logic         fast_rc_osc, slow_rc_osc, fast_osc_ready, slow_osc_ready;
    logic [2:0]   active_sel;
    scm_osc_ctl_t osc_ctl;
    scm_clk_en_t  clk_en;
    scm_pd_evt_t  pd_evt;
    scm_state_t   power_state;
    int           miscompares = 0, n_compared = 0, cyc = 0;

    always #12.5 core_clk = ~core_clk;

    scm_clock_mode_ctl dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .power_down_instruction(power_down_instruction), .wake_req(wake_req),
        .watchdog_en(watchdog_en), .auto_conversion_en(auto_conversion_en),
        .fast_rc_osc(fast_rc_osc), .slow_rc_osc(slow_rc_osc), .fast_osc_ready(fast_osc_ready),
        .slow_osc_ready(slow_osc_ready), .osc_ctl(osc_ctl), .clk_en(clk_en), .pd_evt(pd_evt),
        .power_state(power_state), .cpu_on(cpu_on), .active_sel(active_sel));
    scm_osc_model #(.HALF(200)) u_fast (.run(osc_ctl.fast_osc_run), .osc(fast_rc_osc),
        .rdy(fast_osc_ready));
    scm_osc_model #(.HALF(1000)) u_slow (.run(osc_ctl.slow_osc_run), .osc(slow_rc_osc),
        .rdy(slow_osc_ready));

    task tally_and_finish;
        if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) {reg_we, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk) reg_we <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk) {reg_re, reg_addr} <= {1'b1, a};
        @(posedge core_clk) reg_re <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask

    task count(input int b, input int len, output int n);
        n = 0;
        repeat (len) begin
            @(negedge core_clk);
            n += int'(clk_en[b] === 1'b1);
        end
    endtask

    task t_regs;
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h01);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'he3);
        wr(8'h05, 8'h00);
        rd(8'h05, 8'h00);
        rd(8'h00, 8'he3);
    endtask

    task t_fen;
        int n;
        wr(8'h00, 8'he0);
        for (int w = 0; w < 2000 && active_sel !== 3'h7; w++) @(posedge core_clk);
        wr(8'h01, 8'h00);
        rd(8'h01, 8'h00);
        `CHK(osc_ctl.fast_osc_run, 1'b0)
        count(3, 100, n);
        `CHK(n, 0)
        wr(8'h01, 8'h01);
        rd(8'h01, 8'h01);
        repeat (100) @(posedge core_clk);
        rd(8'h01, 8'h03);
    endtask

    task t_div;
        int n, w;
        for (int c = 0; c < 8; c++) begin
            wr(8'h00, {c[2:0], 5'h00});
            for (w = 0; w < 4000 && active_sel !== c[2:0]; w++) @(posedge core_clk);
            count(4, 1, n);
            for (w = 0; w < 3000 && clk_en.cpu_clk_en !== 1'b1; w++) @(negedge core_clk);
            n = 0;
            do begin
                @(negedge core_clk);
                n++;
            end while (clk_en.cpu_clk_en !== 1'b1 && n < 3000);
            `CHK(n, (c == 7) ? 80 : (16 << c))
        end
    endtask

    task t_halt;
        int n;
        scm_state_t md [4] = '{SCM_ST_SLEEP, SCM_ST_IDLE_SLOW_ONLY, SCM_ST_IDLE_FAST_ONLY, SCM_ST_IDLE_BOTH_OSC};
        for (int k = 0; k < 4; k++) begin
            wr(8'h00, {6'h00, k[1:0]});
            @(posedge core_clk) power_down_instruction <= 1'b1;
            @(posedge core_clk) power_down_instruction <= 1'b0;
            @(negedge core_clk);
            `CHK(power_state, md[k])
            `CHK(pd_evt, 3'h7)
            `CHK(osc_ctl.fast_osc_run, k[1])
            count(2, 200, n);
            `CHK(n != 0, k[0])
            if (k == 0) begin
                `CHK(osc_ctl.slow_osc_run, 1'b1)
                count(1, 100, n);
                `CHK(n != 0, 1'b1)
                count(0, 100, n);
                `CHK(n, 0)
                @(posedge core_clk) watchdog_en <= 1'b0;
                @(negedge core_clk) `CHK(osc_ctl.slow_osc_run, 1'b0)
                @(posedge core_clk) auto_conversion_en <= 1'b1;
                @(negedge core_clk) `CHK(osc_ctl.slow_osc_run, 1'b1)
                count(0, 400, n);
                `CHK(n != 0, 1'b1)
            end
            @(posedge core_clk) {wake_req, watchdog_en, auto_conversion_en} <= 3'b110;
            @(posedge core_clk) wake_req <= 1'b0;
            @(negedge core_clk) `CHK(power_state, SCM_ST_RUN)
        end
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            tally_and_finish;
        end
    end

    initial begin
        {reg_addr, reg_wdata, reg_we, reg_re} = 18'h0;
        {power_down_instruction, wake_req, auto_conversion_en} = 3'h0;
        watchdog_en = 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        t_regs;
        t_fen;
        t_div;
        t_halt;
        tally_and_finish;
    end
endmodule

// File: test/scm_monitor.sv
// scm_monitor: port-level assertions for the clock and power mode controller.
// assumes it is bound to scm_clock_mode_ctl and sees only that module's ports.
`timescale 1ns/100ps
module scm_monitor
    import scm_pkg::*;
(
    input wire logic         core_clk,
    input wire logic         rst,
    input wire logic [7:0]   reg_addr,
    input wire logic [7:0]   reg_wdata,
    input wire logic         reg_we,
    input wire logic         reg_re,
    input wire logic [7:0]   reg_rdata,
    input wire logic         power_down_instruction,
    input wire logic         watchdog_en,
    input wire logic         auto_conversion_en,
    input wire scm_osc_ctl_t osc_ctl,
    input wire scm_clk_en_t  clk_en,
    input wire scm_pd_evt_t  pd_evt,
    input wire scm_state_t   power_state,
    input wire logic         cpu_on
);
    logic [2:0] sel_q;
    logic [1:0] keep_q;
    scm_state_t mode_d;
    wire        halt_ok = power_down_instruction && power_state == SCM_ST_RUN;

    // shadow of the control register, so read-back is judged against what was written
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel_q  <= 3'h0;
            keep_q <= 2'h0;
        end else if (reg_we && reg_addr == SCM_SCC_ADDR) begin
            sel_q  <= reg_wdata[7:5];
            keep_q <= reg_wdata[1:0];
        end
    end

    always_comb begin
        case (keep_q)
            2'h0:    mode_d = SCM_ST_SLEEP;
            2'h1:    mode_d = SCM_ST_IDLE_SLOW_ONLY;
            2'h2:    mode_d = SCM_ST_IDLE_FAST_ONLY;
            default: mode_d = SCM_ST_IDLE_BOTH_OSC;
        endcase
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_PD_MODE: assert property (halt_ok |=> power_state == $past(mode_d))
        else $error("power-down mode does not follow keep bits");
    AST_PD_EVT: assert property (halt_ok |=> pd_evt == 3'h7 ##1 pd_evt == 3'h0)
        else $error("power-down event pulses wrong");
    AST_CPU_OFF: assert property (power_state != SCM_ST_RUN |-> !cpu_on && !clk_en.cpu_clk_en)
        else $error("cpu clocked while halted");
    AST_FAST_KEEP: assert property (power_state != SCM_ST_RUN |-> osc_ctl.fast_osc_run == keep_q[1])
        else $error("fast run request differs from keep bit");
    AST_SUB_GATE: assert property (power_state inside {SCM_ST_SLEEP, SCM_ST_IDLE_FAST_ONLY} |-> !clk_en.slow_clk_en)
        else $error("slow clock enable while slow keep bit clear");
    AST_SLEEP_WDT: assert property (power_state == SCM_ST_SLEEP && watchdog_en |-> osc_ctl.slow_osc_run)
        else $error("slow oscillator stopped with watchdog on");
    AST_ACF_GATE: assert property (power_state == SCM_ST_SLEEP && !auto_conversion_en |-> !clk_en.acf_clk_en)
        else $error("conversion clock runs while disabled");
    AST_RD_DATA: assert property (reg_re && reg_addr == SCM_SCC_ADDR |=> reg_rdata == {sel_q, 3'h0, keep_q})
        else $error("control register read-back wrong");

    cover property (halt_ok && keep_q == 2'h0);
    cover property (halt_ok && keep_q == 2'h3);
    cover property (clk_en.cpu_clk_en && sel_q == 3'h6);
    cover property (power_state == SCM_ST_SLEEP && clk_en.acf_clk_en);
endmodule

bind scm_clock_mode_ctl scm_monitor u_mon (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .power_down_instruction(power_down_instruction), .watchdog_en(watchdog_en),
    .auto_conversion_en(auto_conversion_en), .osc_ctl(osc_ctl), .clk_en(clk_en), .pd_evt(pd_evt),
    .power_state(power_state), .cpu_on(cpu_on));

// File: test/scm_osc_model.sv
// scm_osc_model: behavioural rc oscillator with a stable level.
// assumes run is the controller's run request; output stands low while stopped.
`timescale 1ns/100ps
module scm_osc_model #(
    parameter int HALF = 200
) (
    input  wire logic run,
    output logic      osc,
    output logic      rdy
);
    initial begin
        osc = 1'b0;
        rdy = 1'b0;
        forever begin
            if (run !== 1'b1) begin
                // a restarted oscillator is unstable for a while, so ready drops with it
                osc = 1'b0;
                rdy = 1'b0;
                wait (run === 1'b1);
                // the extra 5 ns keeps oscillator edges off the core clock's edges
                #(4 * HALF + 5) rdy = 1'b1;
            end
            #HALF osc = ~osc & run;
        end
    end
endmodule
